/* File: ifb_regs.vh */
// register offsets, flag positions and implemented-bit masks for the interrupt flag bank
`ifndef IFB_REGS_VH
`define IFB_REGS_VH

// byte offsets on the register bus
`define IFB_OFS_FLAGS0 4'h0
`define IFB_OFS_FLAGS1 4'h4
`define IFB_OFS_FLAGS4 4'h8
`define IFB_OFS_ALLOW0 4'hc

// flag word 0
`define IFB_F0_EXT0 0
`define IFB_F0_CAP1 1
// flag word 1
`define IFB_F1_I2CS 0
`define IFB_F1_I2CM 1
`define IFB_F1_PCHG 3
`define IFB_F1_EXT1 4
`define IFB_F1_CAP7 6
`define IFB_F1_CAP8 7
`define IFB_F1_EXT2 13
// flag word 4
`define IFB_F4_SERR 1

// implemented-bit masks
`define IFB_MASK0 16'h0003
`define IFB_MASK1 16'h20db
`define IFB_MASK4 16'h0002

`define IFB_RESP_OKAY 2'h0
`define IFB_RESP_SLVERR 2'h2
`define IFB_ZERO16 16'h0000
`endif

/* File: ifb_flag_bank.v */
// interrupt request flag bank with an axi4-lite register port
`timescale 1ns/1ps
`include "ifb_regs.vh"
// How it works
// - bit 1 of word 0: capture 1 pending
// - bit 0 of word 0: external line 0
// - flag reads 1 once request occurred
// - unimplemented bits read zero, ignore writes
// - each word 0 flag paired with an allow bit; words 1 and 4 have no allow bits
module ifb_flag_bank (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] evt_word0,
    input wire [15:0] evt_word1,
    input wire [15:0] evt_word4,
    output reg [15:0] req_word0,
    output reg [15:0] req_word1,
    output reg [15:0] req_word4
);

// ----------------------------------------
// write channel capture
// ----------------------------------------
reg aw_held_r;
reg w_held_r;
reg [3:0] aw_addr_r;
reg [15:0] w_data_r;
reg [1:0] w_strb_r;
reg [15:0] flags0_r, flags1_r, flags4_r, allow0_r;
wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

function [15:0] lane_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] strb;
    input [15:0] mask;
    begin
        lane_merge = old_v;
        if (strb[0]) lane_merge[7:0] = new_v[7:0];
        if (strb[1]) lane_merge[15:8] = new_v[15:8];
        lane_merge = lane_merge & mask;
    end
endfunction

function addr_ok;
    input [3:0] a;
    begin
        addr_ok = (a == `IFB_OFS_FLAGS0) || (a == `IFB_OFS_FLAGS1) ||
                  (a == `IFB_OFS_FLAGS4) || (a == `IFB_OFS_ALLOW0);
    end
endfunction

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        aw_addr_r <= 4'h0;
        w_data_r <= `IFB_ZERO16;
        w_strb_r <= 2'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `IFB_RESP_OKAY;
    end else begin
        s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
        s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[3:2], 2'h0};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[15:0];
            w_strb_r <= s_axi_wstrb[1:0];
        end
        if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(aw_addr_r) ? `IFB_RESP_OKAY : `IFB_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// flag storage
// ----------------------------------------
// the written value replaces the flag, then a same-cycle event is ored on top so it is never lost
wire [15:0] sw0 = (wr_go && aw_addr_r == `IFB_OFS_FLAGS0) ?
                  lane_merge(flags0_r, w_data_r, w_strb_r, `IFB_MASK0) : flags0_r;
wire [15:0] sw1 = (wr_go && aw_addr_r == `IFB_OFS_FLAGS1) ?
                  lane_merge(flags1_r, w_data_r, w_strb_r, `IFB_MASK1) : flags1_r;
wire [15:0] sw4 = (wr_go && aw_addr_r == `IFB_OFS_FLAGS4) ?
                  lane_merge(flags4_r, w_data_r, w_strb_r, `IFB_MASK4) : flags4_r;

always @(posedge aclk) begin
    if (!aresetn) begin
        flags0_r <= `IFB_ZERO16;
        flags1_r <= `IFB_ZERO16;
        flags4_r <= `IFB_ZERO16;
        allow0_r <= `IFB_ZERO16;
    end else begin
        flags0_r <= sw0 | (evt_word0 & `IFB_MASK0);
        flags1_r <= sw1 | (evt_word1 & `IFB_MASK1);
        flags4_r <= sw4 | (evt_word4 & `IFB_MASK4);
        if (wr_go && aw_addr_r == `IFB_OFS_ALLOW0)
            allow0_r <= lane_merge(allow0_r, w_data_r, w_strb_r, `IFB_MASK0);
    end
end

// ----------------------------------------
// request outputs
// ----------------------------------------
// only word 0 has an allow register here; other words pass unchanged
always @(posedge aclk) begin
    if (!aresetn) begin
        req_word0 <= `IFB_ZERO16;
        req_word1 <= `IFB_ZERO16;
        req_word4 <= `IFB_ZERO16;
    end else begin
        req_word0 <= flags0_r & allow0_r;
        req_word1 <= flags1_r;
        req_word4 <= flags4_r;
    end
end

// ----------------------------------------
// read channel
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `IFB_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `IFB_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'h0})
                `IFB_OFS_FLAGS0: s_axi_rdata <= {16'h0000, flags0_r};
                `IFB_OFS_FLAGS1: s_axi_rdata <= {16'h0000, flags1_r};
                `IFB_OFS_FLAGS4: s_axi_rdata <= {16'h0000, flags4_r};
                `IFB_OFS_ALLOW0: s_axi_rdata <= {16'h0000, allow0_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `IFB_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // ifb_flag_bank

/* File: ifb_chk_sva.sv */
// checker on the flag bank ports
`timescale 1ns/1ps
module ifb_chk (input wire aclk, input wire aresetn, input wire s_axi_wvalid, input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    input wire [31:0] s_axi_rdata, input wire [15:0] evt_word0, input wire [15:0] evt_word1,
    input wire [15:0] evt_word4, input wire [15:0] req_word0, input wire [15:0] req_word1,
    input wire [15:0] req_word4);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ext2_set_a: assert property (evt_word1[13] |-> ##2 req_word1[13]) else $error("ext2 lost");
    serr_set_a: assert property (evt_word4[1] |-> ##2 req_word4[1]) else $error("serr lost");
    unused_zero_a: assert property (!req_word4[0] && !(req_word1 & 16'hdf24) && !req_word0[15:2])
        else $error("unused bit set");
    rdata_hi_a: assert property (s_axi_rvalid |-> !s_axi_rdata[31:16]) else $error("rdata high");
    // a flag only drops after a completed write, whose response rose one cycle earlier
    flag_hold_a: assert property ($fell(req_word1[3]) |-> $past(s_axi_bvalid)) else $error("flag lost");
    allow_gate_a: assert property ($rose(req_word0[1]) |-> $past(evt_word0[1], 2) || $past(s_axi_bvalid))
        else $error("req without cause");
endmodule // ifb_chk
bind ifb_flag_bank ifb_chk chk (.*);

/* File: ifb_evt_src.sv */
// peripheral event source model
`timescale 1ns/1ps
module ifb_evt_src (input wire aclk, input wire [47:0] go, output reg [47:0] evt);
    initial evt = 48'h0;
    always @(posedge aclk) evt <= go;
endmodule // ifb_evt_src

/* File: interrupt_flag_status_bank_tb.sv */
// testbench for the interrupt flag bank
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, g, e); end end
module interrupt_flag_status_bank_tb;
    reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    reg s_axi_rready = 0;
    reg [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [47:0] go = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] evt_word0, evt_word1, evt_word4, req_word0, req_word1, req_word4;
    integer fails = 0, num_checks = 0, cyc = 0, i;
    ifb_flag_bank uut (.*);
    ifb_evt_src src (.aclk(aclk), .go(go), .evt({evt_word4, evt_word1, evt_word0}));
    always #20 aclk = ~aclk;
    task stop_test; begin
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end endtask
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin fails++; stop_test; end
    end
    task wr(input [3:0] a, input [15:0] d); begin
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= {16'h0, d}; s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
        `CHK(s_axi_bresp, 2'h0)
    end endtask
    task rd(input [3:0] a, input [15:0] e); begin
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
        `CHK(s_axi_rdata, {16'h0, e})
        `CHK(s_axi_rresp, 2'h0)
    end endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        for (i = 0; i < 16; i = i + 4) rd(i[3:0], 16'h0);
        $display("reset test done");
        @(posedge aclk) go <= '1;
        @(posedge aclk) go <= 0;
        repeat (3) @(posedge aclk);
        rd(4'h0, 16'h0003);
        rd(4'h4, 16'h20db);
        rd(4'h8, 16'h0002);
        `CHK(req_word0, 16'h0)
        $display("event test done");
        wr(4'hc, 16'hffff);
        // the request follows the allow word one cycle after the write lands
        @(negedge aclk);
        `CHK(req_word0, 16'h0003)
        rd(4'hc, 16'h0003);
        wr(4'h4, 16'h0);
        rd(4'h4, 16'h0);
        wr(4'h4, 16'hffff);
        rd(4'h4, 16'h20db);
        wr(4'h0, 16'h0002);
        rd(4'h0, 16'h0002);
        $display("write test done");
        stop_test;
    end
endmodule // interrupt_flag_status_bank_tb
